/* File: tsfa_pkg.sv */
/*
   shared constants, types and state encoding for the two-step flash
   converter sequencer.
   assumes a single 100 MHz clock domain.
*/
package tsfa_pkg;

   // ----------------------------------------
   // conversion timing
   // ----------------------------------------
   localparam int          CONV_PERIODS   = 3;
   localparam int          HOLD_PERIODS   = 1;
   localparam int          TRACK_PERIODS  = 2;
   localparam int          INIT_PERIODS   = 6;
   localparam int          FIRST_EXTRA    = 1;
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          WR_MAX_NS      = 200;
   localparam int          WR_MAX_CYC     = WR_MAX_NS / CLK_PERIOD_NS;

   // ----------------------------------------
   // result layout
   // ----------------------------------------
   localparam int          HALF_W         = 5;
   localparam int          DATA_W         = 10;
   localparam int          SIGN_POS       = 9;
   localparam logic [9:0]  POS_FULL       = 10'h1ff;
   localparam logic [9:0]  NEG_FULL       = 10'h200;
   localparam logic [8:0]  MAG_ZERO       = 9'h000;
   localparam logic [4:0]  HALF_ZERO      = 5'h00;

   // ----------------------------------------
   // types
   // ----------------------------------------
   typedef enum logic [1:0]
   {
      TSFA_IDLE  = 2'b00,
      TSFA_HOLD  = 2'b01,
      TSFA_FINE  = 2'b11,
      TSFA_XFER  = 2'b10
   } tsfa_state_type;

   typedef struct packed
   {
      logic       outOfRange;
      logic [9:0] data;
   } tsfa_result_type;

   typedef struct packed
   {
      logic       overRange;
      logic       negative;
      logic [4:0] bits;
   } tsfa_flash_type;

endpackage

/* File: tsfa_buffer.sv */
/*
   two-entry skid buffer for converter results.
   assumes source and sink share the sequencer clock.
*/
`timescale 1ns/10ps
module tsfa_buffer
   import tsfa_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire tsfa_result_type inData,
   input  wire logic            inValid,
   output logic                 inReady,
   output tsfa_result_type      outData,
   output logic                 outValid,
   input  wire logic            outReady
);

   tsfa_result_type             store [2];
   logic                        wrPtr;
   logic                        rdPtr;
   logic [1:0]                  count;

   // ----------------------------------------
   // pointers and occupancy
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         wrPtr <= 1'b0;
         rdPtr <= 1'b0;
         count <= 2'h0;
      end
      else
      begin
         if (inValid && inReady)
            wrPtr <= ~wrPtr;
         if (outValid && outReady)
            rdPtr <= ~rdPtr;
         count <= count + 2'((inValid && inReady) ? 1 : 0)
                        - 2'((outValid && outReady) ? 1 : 0);
      end
   end

   always_ff @(posedge clock)
   begin
      if (inValid && inReady)
         store[wrPtr] <= inData;
   end

   assign inReady  = (count != 2'h2);
   assign outValid = (count != 2'h0);
   assign outData  = store[rdPtr];

endmodule

/* File: tsfa_sequencer.sv */
/*
   sequencer and result formatting for a two-step flash 10-bit converter.
   assumes the analog flash comparator results arrive as sampled levels
   on the same clock; the start strobe is an asynchronous pin.
*/
// Function
// (R1) each conversion takes three input clock periods; the code takes four for a conversion started from idle, in either mode
// (R2) track/hold is in hold for exactly one period at conversion start
// (R3) track/hold then tracks for the remaining two periods
// (R4) comparators zero, compare; coarse result valid at third half period
// (R5) coarse result goes to upper five bits of first-level latch
// (R6) fine compare in sixth half period, result on next edge
// (R7) fine result goes to lower five bits of first-level latch
// (R8) ten data bits and out-of-range bit move together to output latch
// (R9) result is two's complement, bit 9 the sign
// (R10) positive full scale 1ff, zero 000, negative full scale 200
// (R11) overrange sets flag, clears magnitude, sign gives direction
// (R12) hold timing drives the active-low hold pin
// (R13) continuous modes: first conversion longer, then back to back
// (R14) host keeps start strobe low no longer than its maximum width
// (R15) continuous modes: six periods of initialisation before converting
// (R16) fast memory: first hold follows falling edge of start strobe
// (R17) three-state cycle counter, restarted by each start event; the code ignores a start that falls during hold or while stalled
`timescale 1ns/10ps
module tsfa_sequencer
   import tsfa_pkg::*;
(
   input  wire logic            clock,
   input  wire logic            rst,
   input  wire logic            startStrobe_n,
   input  wire logic            interfaceModeSelect,
   input  wire tsfa_flash_type  flashResult,
   output logic                 hold_n,
   output logic                 coarseStrobe,
   output logic                 fineStrobe,
   output logic                 outOfRangeFlag,
   output logic [9:0]           resultData,
   output logic                 resultValid,
   input  wire logic            resultReady,
   output logic                 busy_n
);

   // ----------------------------------------
   // start strobe synchroniser
   // ----------------------------------------
   logic [2:0]                  startSync;
   logic                        startLevel;
   logic                        startFall;
   logic                        continuous;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         startSync  <= 3'h7;
         startLevel <= 1'b1;
      end
      else
      begin
         startSync <= {startSync[1:0], startStrobe_n};
         if (startSync[2] == startSync[1])
            startLevel <= startSync[2];
      end
   end

   // falling edge counts once both later stages agree
   assign startFall  = startLevel && (startSync[2] == startSync[1]) && !startSync[2];
   // low mode select means free-running conversions
   assign continuous = !interfaceModeSelect;

   // ----------------------------------------
   // initialisation count for continuous modes
   // ----------------------------------------
   logic [2:0]                  initCount;
   logic                        initDone;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         initCount <= 3'h0;
      else if (continuous && !initDone)
         initCount <= initCount + 3'h1; // see (R15)
      else if (!continuous)
         initCount <= 3'h0;
   end

   assign initDone = (initCount == 3'(INIT_PERIODS));

   // ----------------------------------------
   // cycle counter
   // ----------------------------------------
   tsfa_state_type              state;
   tsfa_state_type              next_state;
   logic                        firstConv;
   logic                        extraDone;
   logic                        startEvent;
   logic                        stall;
   logic                        bufInReady;

   // a stalled receiver freezes the sequence rather than dropping a word
   assign stall      = (state == TSFA_XFER) && !bufInReady;
   assign startEvent = continuous ? initDone : startFall; // see (R16)

   always_comb
   begin
      next_state = state;
      case (state)
         TSFA_IDLE:
            if (startEvent)
               next_state = TSFA_HOLD; // see (R17)
         TSFA_HOLD:
            next_state = TSFA_FINE;
         TSFA_FINE:
            if (!firstConv || extraDone)
               next_state = TSFA_XFER; // see (R13)
         TSFA_XFER:
            if (stall)
               next_state = TSFA_XFER;
            else if (continuous || startFall)
               next_state = TSFA_HOLD; // see (R1)
            else
               next_state = TSFA_IDLE;
         default:
            next_state = TSFA_IDLE;
      endcase
      // restart decided here so hold pin and strobes follow it; on a restart from fine the old sample is dropped
      if (!continuous && state != TSFA_IDLE && state != TSFA_HOLD && startFall && !stall)
         next_state = TSFA_HOLD; // see (R17)
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         state <= TSFA_IDLE;
      else
         state <= next_state;
   end

   // first conversion after leaving idle is one period longer
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         firstConv <= 1'b1;
         extraDone <= 1'b0;
      end
      else
      begin
         if (state == TSFA_IDLE)
            firstConv <= 1'b1;
         else if (state == TSFA_XFER && !stall)
            firstConv <= 1'b0; // see (R13)
         if (state == TSFA_FINE && firstConv)
            extraDone <= 1'b1;
         else
            extraDone <= 1'b0;
      end
   end

   // ----------------------------------------
   // hold pin and phase strobes
   // ----------------------------------------
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         hold_n       <= 1'b1;
         coarseStrobe <= 1'b0;
         fineStrobe   <= 1'b0;
         busy_n       <= 1'b1;
      end
      else
      begin
         hold_n       <= !(next_state == TSFA_HOLD && state != TSFA_HOLD); // see (R2)
         coarseStrobe <= (next_state == TSFA_HOLD); // see (R4)
         fineStrobe   <= (state == TSFA_FINE) && (next_state == TSFA_XFER); // see (R6)
         busy_n       <= (next_state == TSFA_IDLE);
      end
   end
   // hold_n high for the two tracking periods follows from the above, see (R3) (R12)

   // ----------------------------------------
   // first-level latch
   // ----------------------------------------
   logic [4:0]                  coarseBits;
   logic [4:0]                  fineBits;
   logic                        overRange;
   logic                        overNeg;

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         coarseBits <= HALF_ZERO;
         fineBits   <= HALF_ZERO;
         overRange  <= 1'b0;
         overNeg    <= 1'b0;
      end
      else
      begin
         if (state == TSFA_HOLD)
         begin
            coarseBits <= flashResult.bits; // see (R5)
            overRange  <= flashResult.overRange;
            overNeg    <= flashResult.negative;
         end
         if (state == TSFA_FINE && next_state == TSFA_XFER)
            fineBits <= flashResult.bits; // see (R7)
      end
   end

   // ----------------------------------------
   // formatting and output latch
   // ----------------------------------------
   function automatic tsfa_result_type formatResult(
      input logic       out_of_range_flag,
      input logic       neg,
      input logic [9:0] raw
   );
      tsfa_result_type r;
      r.outOfRange = out_of_range_flag;
      if (out_of_range_flag)
         r.data = {neg, MAG_ZERO}; // see (R11)
      else
         r.data = raw; // see (R9) (R10)
      return r;
   endfunction

   tsfa_result_type             bufIn;
   tsfa_result_type             bufOut;
   logic                        bufOutValid;

   assign bufIn = formatResult(overRange, overNeg, {coarseBits, fineBits});

   tsfa_buffer u_buffer
   (
      .clock    (clock),
      .rst      (rst),
      .inData   (bufIn),
      .inValid  (state == TSFA_XFER),
      .inReady  (bufInReady),
      .outData  (bufOut),
      .outValid (bufOutValid),
      .outReady (!resultValid || resultReady)
   );

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         resultData     <= 10'h000;
         outOfRangeFlag <= 1'b0;
         resultValid    <= 1'b0;
      end
      else if (!resultValid || resultReady)
      begin
         resultValid <= bufOutValid;
         if (bufOutValid)
         begin
            resultData     <= bufOut.data; // see (R8)
            outOfRangeFlag <= bufOut.outOfRange;
         end
      end
   end

endmodule

/* File: tsfa_seq_checker.sv */
/*
   port assertions for the converter sequencer.
   assumes a bind from the bench top onto tsfa_sequencer.
*/
`timescale 1ns/10ps
module tsfa_seq_checker
   import tsfa_pkg::*;
(
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       interfaceModeSelect,
   input  wire logic       hold_n,
   input  wire logic       coarseStrobe,
   input  wire logic       fineStrobe,
   input  wire logic       outOfRangeFlag,
   input  wire logic [9:0] resultData,
   input  wire logic       resultValid,
   input  wire logic       resultReady
);
   // ----------------------------------------
   // sequences and properties
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   sequence s_holdStart;
      $fell(hold_n);
   endsequence

   // only judged when the sink is ready at the hold fall, since a full buffer delays transfer
   sequence s_contHold;
      !interfaceModeSelect && resultReady && $fell(hold_n);
   endsequence

   property p_holdOne;
      s_holdStart |=> hold_n;
   endproperty
   property p_trackTwo;
      s_holdStart |=> hold_n [*2];
   endproperty
   property p_coarsePulse;
      coarseStrobe |=> !coarseStrobe;
   endproperty
   property p_fineAfter;
      coarseStrobe |-> ##[1:3] fineStrobe;
   endproperty
   property p_stand;
      resultValid && !resultReady |=>
         resultValid && $stable(resultData) && $stable(outOfRangeFlag);
   endproperty
   property p_ovrFormat;
      resultValid && outOfRangeFlag |-> resultData[8:0] == MAG_ZERO;
   endproperty
   property p_deliver;
      fineStrobe && resultReady |-> ##[1:6] resultValid;
   endproperty
   property p_rate;
      s_contHold |-> ##[3:4] $fell(hold_n);
   endproperty

   a_holdOne:     assert property (p_holdOne)     else $error("hold low not one cycle");
   a_trackTwo:    assert property (p_trackTwo)    else $error("track shorter than two");
   a_coarsePulse: assert property (p_coarsePulse) else $error("coarse strobe too long");
   a_fineAfter:   assert property (p_fineAfter)   else $error("no fine after coarse");
   a_stand:       assert property (p_stand)       else $error("result moved in stall");
   a_ovrFormat:   assert property (p_ovrFormat)   else $error("overrange magnitude set");
   a_deliver:     assert property (p_deliver)     else $error("result not delivered");
   a_rate:        assert property (p_rate)        else $error("conversion spacing wrong");
endmodule

/* File: tsfa_sink_model.sv */
/*
   ready logic on the far side of the result stream.
   assumes stall is driven by the bench; ready moves only after a rising edge.
*/
`timescale 1ns/10ps
module tsfa_sink_model
   import tsfa_pkg::*;
(
   input  wire logic clock,
   input  wire logic rst,
   input  wire logic stall,
   output logic      resultReady
);
   // ----------------------------------------
   // ready generation
   // ----------------------------------------
   // registered so the sequencer never sees ready change near its sampling edge
   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         resultReady <= 1'b0;
      else
         resultReady <= !stall;
   end
endmodule

/* File: two_step_flash_adc_sequencer_tb.sv */
/*
   self-checking bench for the converter sequencer.
   assumes the package, design, checker and sink model are compiled first.
*/
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; \
   $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module two_step_flash_adc_sequencer_tb
   import tsfa_pkg::*;
;
   logic clock = 0, rst = 1, startStrobe_n = 1, interfaceModeSelect = 1, stall = 0;
   logic hold_n, coarseStrobe, fineStrobe, outOfRangeFlag, resultValid, resultReady, busy_n;
   logic [9:0] resultData;
   logic [10:0] q[$];
   logic [9:0] codes[5] = '{10'h1ff, 10'h000, 10'h200, 10'h001, 10'h3ff};
   tsfa_flash_type flash = '0, coarseV = '0, fineV = '0;
   logic coarseD = 0, fineD = 0, holdPrev = 1;
   int errors = 0, comparisons = 0, holdLow = 0, busyLow = 0, cyc = 0;
   int falls[$];

   // ----------------------------------------
   // clock, design and partner
   // ----------------------------------------
   always #5 clock = ~clock;
   tsfa_sequencer dut (.clock, .rst, .startStrobe_n, .interfaceModeSelect,
      .flashResult(flash), .hold_n, .coarseStrobe, .fineStrobe, .outOfRangeFlag,
      .resultData, .resultValid, .resultReady, .busy_n);
   tsfa_sink_model sink (.clock, .rst, .stall, .resultReady);

   // ----------------------------------------
   // comparator source and monitor
   // ----------------------------------------
   // coarse value stays until the coarse phase has passed, fine value after it
   always @(negedge clock)
   begin
      if (coarseD) flash = fineV;
      else if (fineD) flash = coarseV;
      coarseD = coarseStrobe;
      fineD = fineStrobe;
      if (resultValid && resultReady) q.push_back({outOfRangeFlag, resultData});
      if (!hold_n) holdLow++;
      if (!busy_n) busyLow++;
      if (!hold_n && holdPrev) falls.push_back(cyc);
      holdPrev = hold_n;
      cyc++;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic convert(input tsfa_flash_type c, input tsfa_flash_type f);
      coarseV = c;
      fineV = f;
      flash = c;
      startStrobe_n = 0;
      repeat (2) @(negedge clock);
      startStrobe_n = 1;
      repeat (14) @(negedge clock);
   endtask

   task automatic wait_words(input int n);
      for (int k = 0; k < 60 && q.size() < n; k++) @(negedge clock);
      `CHK(q.size() >= n, 1'b1)
   endtask

   task automatic t_codes();
      foreach (codes[i])
      begin
         q.delete();
         holdLow = 0;
         busyLow = 0;
         convert({2'b00, codes[i][9:5]}, {2'b00, codes[i][4:0]});
         wait_words(1);
         `CHK(q[0], {1'b0, codes[i]})
         `CHK(holdLow, HOLD_PERIODS)
         `CHK(busyLow, CONV_PERIODS + FIRST_EXTRA)
      end
   endtask

   task automatic t_ovr();
      for (int n = 0; n < 2; n++)
      begin
         q.delete();
         convert({1'b1, n[0], 5'h15}, {1'b1, n[0], 5'h0a});
         wait_words(1);
         `CHK(q[0], {1'b1, n[0], 9'h000})
      end
   endtask

   task automatic t_stall();
      q.delete();
      stall = 1;
      convert({2'b00, 5'h03}, {2'b00, 5'h1c});
      convert({2'b00, 5'h1e}, {2'b00, 5'h01});
      `CHK(q.size(), 0)
      `CHK(resultValid, 1'b1)
      stall = 0;
      wait_words(2);
      `CHK(q[0], 11'h07c)
      `CHK(q[1], 11'h3c1)
   endtask

   task automatic t_cont();
      int c0;
      coarseV = {2'b00, 5'h0b};
      fineV = coarseV;
      flash = coarseV;
      q.delete();
      falls.delete();
      interfaceModeSelect = 0;
      c0 = cyc;
      repeat (40) @(negedge clock);
      `CHK(falls.size() >= 5, 1'b1)
      // monitor may count the mode-change edge before or after c0 is taken
      `CHK((falls[0] - c0 >= INIT_PERIODS) && (falls[0] - c0 <= INIT_PERIODS + 1), 1'b1)
      `CHK(falls[1] - falls[0], CONV_PERIODS + FIRST_EXTRA)
      for (int i = 2; i < falls.size(); i++)
         `CHK(falls[i] - falls[i - 1], CONV_PERIODS)
      `CHK(q[q.size() - 1], 11'h16b)
   endtask

   task automatic end_sim();
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      repeat (2) @(posedge clock);
      @(negedge clock);
      rst = 0;
      repeat (2) @(negedge clock);
      t_codes();
      t_ovr();
      t_stall();
      t_cont();
      end_sim();
   end

   initial
   begin
      #20000;
      errors++;
      end_sim();
   end
endmodule

bind tsfa_sequencer tsfa_seq_checker chk (.clock, .rst, .interfaceModeSelect, .hold_n,
   .coarseStrobe, .fineStrobe, .outOfRangeFlag, .resultData, .resultValid, .resultReady);
